/* File: hftx_checker.sv */
// port assertions of the frame trigger exposure block
`timescale 1ns/1ps
`include "hftx_defines.svh"

module hftx_checker (
  // clock and reset
  input wire logic                    clk_in,
  input wire logic                    rst_in,
  // register port
  input wire logic [`HFTX_ADDR_W-1:0] addr_in,
  input wire logic [31:0]             wdata_in,
  input wire logic                    wr_in,
  input wire logic                    rd_in,
  input wire logic [31:0]             rdata_out,
  // trigger and status
  input wire logic                    hw_frame_trigger_input_in,
  input wire logic                    frame_trigger_ready_out,
  input wire logic                    frame_start_out,
  input wire logic                    irq_out
);
  logic [4:0]  ctrl_ff;
  logic [31:0] exp_ff, min_ff, cnt_ff;
  logic        dly0_ff, mask0_ff, armed_ff, rd_ff, inexp_ff, pw_ff;
  // shadows of the writes; a mid exposure rewrite is not modelled
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_ff <= 5'h00; exp_ff <= 32'hBB8; min_ff <= 32'hBB8; dly0_ff <= 1'b1; mask0_ff <= 1'b1;
      armed_ff <= 1'b0; rd_ff <= 1'b0; inexp_ff <= 1'b0; pw_ff <= 1'b0; cnt_ff <= 32'h0;
    end else begin
      rd_ff <= rd_in;
      cnt_ff <= frame_start_out ? 32'h0 : cnt_ff + 32'h1;
      inexp_ff <= frame_start_out | (inexp_ff & ~frame_trigger_ready_out);
      if (frame_start_out) pw_ff <= ctrl_ff[3] & ctrl_ff[0] & ~ctrl_ff[1];
      if (wr_in && addr_in == `HFTX_OFS_CTRL) ctrl_ff <= wdata_in[4:0];
      if (wr_in && addr_in == `HFTX_OFS_EXPOSURE) exp_ff <= {8'h00, wdata_in[23:0]};
      if (wr_in && addr_in == `HFTX_OFS_MIN_EXP) min_ff <= {8'h00, wdata_in[23:0]};
      if (wr_in && addr_in == `HFTX_OFS_DELAY) dly0_ff <= (wdata_in == 32'h0);
      if (wr_in && addr_in == `HFTX_OFS_IRQ_MASK) mask0_ff <= (wdata_in[2:0] == 3'h0);
      if (wr_in && addr_in == `HFTX_OFS_CMD && wdata_in[0]) armed_ff <= 1'b1;
      if (wr_in && addr_in == `HFTX_OFS_CMD && wdata_in[1]) armed_ff <= 1'b0;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_rdata_idle: assert property (!rd_ff |-> rdata_out == 32'h0) else $error("read data outside read slot");
  a_start_pulse: assert property (frame_start_out |=> !frame_start_out) else $error("start pulse too long");
  a_start_busy: assert property (frame_start_out |-> !frame_trigger_ready_out) else $error("ready at start");
  a_arm_first: assert property (!armed_ff |-> !frame_start_out) else $error("start without arm");
  a_rise_start: assert property ($rose(hw_frame_trigger_input_in) && frame_trigger_ready_out && dly0_ff
    && (ctrl_ff & 5'h17) == 5'h01 |-> ##[3:6] frame_start_out) else $error("rising edge missed");
  a_fall_start: assert property ($fell(hw_frame_trigger_input_in) && frame_trigger_ready_out && dly0_ff
    && (ctrl_ff & 5'h17) == 5'h05 |-> ##[3:6] frame_start_out) else $error("falling edge missed");
  a_timed_len: assert property ($rose(frame_trigger_ready_out) && inexp_ff && !pw_ff
    |-> cnt_ff inside {[exp_ff * 125 - 2 : exp_ff * 125 + 2]}) else $error("timed length wrong");
  a_pw_ready: assert property ($rose(frame_trigger_ready_out) && inexp_ff && pw_ff
    |-> cnt_ff + 2 >= min_ff * 125) else $error("ready before minimum");
  a_irq_mask: assert property (mask0_ff |-> !irq_out) else $error("masked interrupt seen");
  c_pw: cover property (frame_start_out && ctrl_ff[3]);
  c_irq: cover property ($rose(irq_out));
  c_end: cover property ($rose(frame_trigger_ready_out) && inexp_ff);
  c_gate: cover property (frame_start_out && ctrl_ff[4]);
endmodule // hftx_checker

bind hftx_top hftx_checker hftx_checker_i (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .hw_frame_trigger_input_in(hw_frame_trigger_input_in), .frame_trigger_ready_out(frame_trigger_ready_out),
  .frame_start_out(frame_start_out), .irq_out(irq_out));

/* File: hftx_defines.svh */
// offsets, field positions, reset values and timing counts of the frame trigger exposure block
`ifndef HFTX_DEFINES_SVH
`define HFTX_DEFINES_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define HFTX_ADDR_W           8
`define HFTX_OFS_CTRL         8'h00
`define HFTX_OFS_CMD          8'h04
`define HFTX_OFS_EXPOSURE     8'h08
`define HFTX_OFS_DELAY        8'h0C
`define HFTX_OFS_MIN_EXP      8'h10
`define HFTX_OFS_RATE_PERIOD  8'h14
`define HFTX_OFS_STATUS       8'h18
`define HFTX_OFS_IRQ_STATUS   8'h1C
`define HFTX_OFS_IRQ_MASK     8'h20

// ****************************************
// field positions
// ****************************************
`define HFTX_CTRL_TRIG_EN     0
`define HFTX_CTRL_SRC_SW      1
`define HFTX_CTRL_EDGE_FALL   2
`define HFTX_CTRL_PW_METHOD   3
`define HFTX_CTRL_RATE_GATE   4
`define HFTX_CMD_ARM          0
`define HFTX_CMD_STOP         1
`define HFTX_CMD_SW_TRIG      2
`define HFTX_IRQ_MISSED       0
`define HFTX_IRQ_START        1
`define HFTX_IRQ_END          2
`define HFTX_IRQ_W            3

// ****************************************
// widths and reset values
// ****************************************
`define HFTX_US_W             24
`define HFTX_DELAY_W          20
`define HFTX_DELAY_MAX_US     20'hF4240
`define HFTX_RST_EXPOSURE     24'h000BB8
`define HFTX_RST_MIN_EXP      24'h000BB8
`define HFTX_RST_RATE_PERIOD  24'h004E20
`define HFTX_RST_DELAY        20'h00000

// ****************************************
// timing
// ****************************************
`define HFTX_CLK_PERIOD_NS    8
`define HFTX_US_NS            1000
`define HFTX_TICK_CYCLES      (`HFTX_US_NS / `HFTX_CLK_PERIOD_NS)
`define HFTX_DIV_W            7

`endif

/* File: hftx_pkg.sv */
// types of the frame trigger exposure block
`include "hftx_defines.svh"

package hftx_pkg;

  typedef enum logic [1:0] {
    HFTX_ST_IDLE   = 2'b00,
    HFTX_ST_WAIT   = 2'b01,
    HFTX_ST_DELAY  = 2'b10,
    HFTX_ST_EXPOSE = 2'b11
  } hftx_state_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } hftx_edges_t;

  typedef struct packed {
    logic                     trig_en;
    logic                     src_sw;
    logic                     edge_fall;
    logic                     pw_method;
    logic                     rate_gate;
    logic [`HFTX_US_W-1:0]    exposure_us;
    logic [`HFTX_DELAY_W-1:0] delay_us;
    logic [`HFTX_US_W-1:0]    min_exp_us;
    logic [`HFTX_US_W-1:0]    rate_period_us;
  } hftx_cfg_t;

endpackage

/* File: hftx_top.sv */
// exposure control for hardware frame start triggering
//
// Operation
// - two methods: timed or pulse width
// - timed exposure lasts programmed duration only
// - timed starts on selected edge
// - edge during exposure dropped, missed event
// - pulse width rising: high to low
// - pulse width length unlimited by duration setting
// - pulse width: minimum planned exposure drives trigger ready
// - microsecond delay before trigger acts
// - delay 0 to 1000000 us, zero none
// - no delay when off or software
// - gate cleared: rate follows trigger edges
// - edge select picks rising or falling
// - leave waiting on start, return after
// - duration in whole microseconds
`timescale 1ns/1ps
`include "hftx_defines.svh"

module hftx_top (
  // clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  // register port
  input  wire logic [`HFTX_ADDR_W-1:0]  addr_in,
  input  wire logic [31:0]              wdata_in,
  input  wire logic                     wr_in,
  input  wire logic                     rd_in,
  output logic      [31:0]              rdata_out,
  // trigger pin
  input  wire logic                     hw_frame_trigger_input_in,
  // status outputs
  output logic                          frame_trigger_ready_out,
  output logic                          frame_start_out,
  output logic                          irq_out
);
  import hftx_pkg::*;

  typedef struct packed {
    hftx_state_t               state;
    hftx_cfg_t                 cfg;
    logic                      pw_cur;
    logic [`HFTX_DIV_W-1:0]    div;
    logic [`HFTX_US_W-1:0]     elapsed_us;
    logic [`HFTX_DELAY_W-1:0]  delay_cnt;
    logic [`HFTX_US_W-1:0]     pace_us;
    logic                      ready;
    logic                      start;
    logic [`HFTX_IRQ_W-1:0]    irq_status;
    logic [`HFTX_IRQ_W-1:0]    irq_mask;
    logic [31:0]               rdata;
  } hftx_top_state_t;

  localparam logic [`HFTX_DIV_W-1:0] TICK_LAST = `HFTX_DIV_W'(`HFTX_TICK_CYCLES - 1);

  hftx_top_state_t st_ff;
  hftx_top_state_t nxt_st;
  hftx_edges_t     trig;

  // ****************************************
  // trigger pin synchroniser
  // ****************************************
  hftx_trig_sync u_sync (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .pin_in    (hw_frame_trigger_input_in),
    .edges_out (trig)
  );

  // ****************************************
  // decoded strobes and trigger terms
  // ****************************************
  logic wr_ctrl;
  logic wr_cmd;
  logic rd_irq;
  logic tick;
  logic act_edge;
  logic act_level;
  logic hw_trig;
  logic sw_trig;
  logic pace_ok;
  logic [`HFTX_US_W-1:0] exp_target;

  assign wr_ctrl   = wr_in && (addr_in == `HFTX_OFS_CTRL);
  assign wr_cmd    = wr_in && (addr_in == `HFTX_OFS_CMD);
  assign rd_irq    = rd_in && (addr_in == `HFTX_OFS_IRQ_STATUS);
  assign tick      = (st_ff.div == TICK_LAST);
  // active edge and level follow the edge select
  assign act_edge  = st_ff.cfg.edge_fall ? trig.fall : trig.rise;
  assign act_level = st_ff.cfg.edge_fall ? ~trig.level : trig.level;
  // hardware edges count only while armed and sourced from the pin
  assign hw_trig   = st_ff.cfg.trig_en && !st_ff.cfg.src_sw && act_edge
                     && (st_ff.state != HFTX_ST_IDLE);
  assign sw_trig   = st_ff.cfg.trig_en && st_ff.cfg.src_sw && wr_cmd
                     && wdata_in[`HFTX_CMD_SW_TRIG];
  // gate cleared: no internal pacing, edges set the rate
  assign pace_ok   = !st_ff.cfg.rate_gate
                     || (st_ff.pace_us >= st_ff.cfg.rate_period_us);
  // zero duration still gives one microsecond
  assign exp_target = (st_ff.cfg.exposure_us == '0) ? `HFTX_US_W'(1) : st_ff.cfg.exposure_us;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic start_now;
    logic end_now;
    logic missed;
    logic to_delay;
    logic pw_next;
    start_now = 1'b0;
    end_now   = 1'b0;
    missed    = 1'b0;
    to_delay  = 1'b0;
    pw_next   = 1'b0;
    nxt_st    = st_ff;

    // microsecond divider, restarted at each delay or exposure start
    nxt_st.div = tick ? '0 : st_ff.div + `HFTX_DIV_W'(1);

    // pacing counter saturates so a long idle never wraps
    if (tick && (st_ff.pace_us != '1)) begin
      nxt_st.pace_us = st_ff.pace_us + `HFTX_US_W'(1);
    end

    unique case (st_ff.state)
      HFTX_ST_IDLE: begin
        if (wr_cmd && wdata_in[`HFTX_CMD_ARM]) begin
          nxt_st.state = HFTX_ST_WAIT;
        end
      end
      HFTX_ST_WAIT: begin
        if (hw_trig) begin
          if (!pace_ok) begin
            missed = 1'b1;
          end else if (st_ff.cfg.delay_us == '0) begin
            start_now = 1'b1;
            pw_next   = st_ff.cfg.pw_method;
          end else begin
            to_delay  = 1'b1;
          end
        end else if (sw_trig) begin
          // software starts are timed and never delayed
          if (pace_ok) begin
            start_now = 1'b1;
          end else begin
            missed = 1'b1;
          end
        end else if (!st_ff.cfg.trig_en && pace_ok) begin
          // trigger off: free run, delay not applied
          start_now = 1'b1;
        end
      end
      HFTX_ST_DELAY: begin
        if (hw_trig) begin
          missed = 1'b1;
        end
        if (tick) begin
          nxt_st.delay_cnt = st_ff.delay_cnt + `HFTX_DELAY_W'(1);
          if ((st_ff.delay_cnt + `HFTX_DELAY_W'(1)) >= st_ff.cfg.delay_us) begin
            start_now = 1'b1;
            pw_next   = st_ff.cfg.pw_method;
          end
        end
      end
      HFTX_ST_EXPOSE: begin
        if (hw_trig) begin
          missed = 1'b1;
        end
        if (tick && (st_ff.elapsed_us != '1)) begin
          nxt_st.elapsed_us = st_ff.elapsed_us + `HFTX_US_W'(1);
        end
        if (st_ff.pw_cur) begin
          // pulse width: no duration limit, the pin ends it
          end_now = !act_level;
        end else begin
          // timed: pin level ignored
          end_now = tick && ((st_ff.elapsed_us + `HFTX_US_W'(1)) >= exp_target);
        end
      end
    endcase

    if (to_delay) begin
      nxt_st.state     = HFTX_ST_DELAY;
      nxt_st.delay_cnt = '0;
      nxt_st.div       = '0;
    end
    if (start_now) begin
      nxt_st.state      = HFTX_ST_EXPOSE;
      nxt_st.pw_cur     = pw_next;
      nxt_st.elapsed_us = '0;
      nxt_st.div        = '0;
      nxt_st.pace_us    = '0;
    end
    if (end_now) begin
      nxt_st.state = HFTX_ST_WAIT;
    end
    // stop wins over everything and drops an exposure in flight
    if (wr_cmd && wdata_in[`HFTX_CMD_STOP]) begin
      nxt_st.state = HFTX_ST_IDLE;
      // a start killed by stop must not pulse or raise its event
      start_now    = 1'b0;
    end

    nxt_st.start = start_now;

    // pulse width: ready once the shortest planned pulse has passed
    nxt_st.ready = (nxt_st.state == HFTX_ST_WAIT)
                   || ((nxt_st.state == HFTX_ST_EXPOSE) && nxt_st.pw_cur
                       && (nxt_st.elapsed_us >= st_ff.cfg.min_exp_us));

    // ****************************************
    // register writes
    // ****************************************
    if (wr_ctrl) begin
      nxt_st.cfg.trig_en   = wdata_in[`HFTX_CTRL_TRIG_EN];
      nxt_st.cfg.src_sw    = wdata_in[`HFTX_CTRL_SRC_SW];
      nxt_st.cfg.edge_fall = wdata_in[`HFTX_CTRL_EDGE_FALL];
      nxt_st.cfg.pw_method = wdata_in[`HFTX_CTRL_PW_METHOD];
      nxt_st.cfg.rate_gate = wdata_in[`HFTX_CTRL_RATE_GATE];
    end
    if (wr_in) begin
      unique case (addr_in)
        `HFTX_OFS_EXPOSURE: begin
          nxt_st.cfg.exposure_us = wdata_in[`HFTX_US_W-1:0];
        end
        `HFTX_OFS_DELAY: begin
          // out of range values clamp to one second
          if (wdata_in > 32'(`HFTX_DELAY_MAX_US)) begin
            nxt_st.cfg.delay_us = `HFTX_DELAY_MAX_US;
          end else begin
            nxt_st.cfg.delay_us = wdata_in[`HFTX_DELAY_W-1:0];
          end
        end
        `HFTX_OFS_MIN_EXP: begin
          nxt_st.cfg.min_exp_us = wdata_in[`HFTX_US_W-1:0];
        end
        `HFTX_OFS_RATE_PERIOD: begin
          nxt_st.cfg.rate_period_us = wdata_in[`HFTX_US_W-1:0];
        end
        `HFTX_OFS_IRQ_MASK: begin
          nxt_st.irq_mask = wdata_in[`HFTX_IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // ****************************************
    // interrupt status, set beats read clear
    // ****************************************
    if (rd_irq) begin
      nxt_st.irq_status = '0;
    end
    if (missed) begin
      nxt_st.irq_status[`HFTX_IRQ_MISSED] = 1'b1;
    end
    if (start_now) begin
      nxt_st.irq_status[`HFTX_IRQ_START] = 1'b1;
    end
    if (end_now) begin
      nxt_st.irq_status[`HFTX_IRQ_END] = 1'b1;
    end

    // ****************************************
    // read data, valid the cycle after the strobe
    // ****************************************
    nxt_st.rdata = '0;
    if (rd_in) begin
      unique case (addr_in)
        `HFTX_OFS_CTRL: begin
          nxt_st.rdata[`HFTX_CTRL_TRIG_EN]   = st_ff.cfg.trig_en;
          nxt_st.rdata[`HFTX_CTRL_SRC_SW]    = st_ff.cfg.src_sw;
          nxt_st.rdata[`HFTX_CTRL_EDGE_FALL] = st_ff.cfg.edge_fall;
          nxt_st.rdata[`HFTX_CTRL_PW_METHOD] = st_ff.cfg.pw_method;
          nxt_st.rdata[`HFTX_CTRL_RATE_GATE] = st_ff.cfg.rate_gate;
        end
        `HFTX_OFS_EXPOSURE: begin
          nxt_st.rdata[`HFTX_US_W-1:0] = st_ff.cfg.exposure_us;
        end
        `HFTX_OFS_DELAY: begin
          nxt_st.rdata[`HFTX_DELAY_W-1:0] = st_ff.cfg.delay_us;
        end
        `HFTX_OFS_MIN_EXP: begin
          nxt_st.rdata[`HFTX_US_W-1:0] = st_ff.cfg.min_exp_us;
        end
        `HFTX_OFS_RATE_PERIOD: begin
          nxt_st.rdata[`HFTX_US_W-1:0] = st_ff.cfg.rate_period_us;
        end
        `HFTX_OFS_STATUS: begin
          nxt_st.rdata[1:0] = st_ff.state;
          nxt_st.rdata[2]   = st_ff.ready;
          nxt_st.rdata[3]   = st_ff.pw_cur;
          nxt_st.rdata[4]   = trig.level;
        end
        `HFTX_OFS_IRQ_STATUS: begin
          nxt_st.rdata[`HFTX_IRQ_W-1:0] = st_ff.irq_status;
        end
        `HFTX_OFS_IRQ_MASK: begin
          nxt_st.rdata[`HFTX_IRQ_W-1:0] = st_ff.irq_mask;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff                    <= '0;
      st_ff.state              <= HFTX_ST_IDLE;
      st_ff.cfg.exposure_us    <= `HFTX_RST_EXPOSURE;
      st_ff.cfg.min_exp_us     <= `HFTX_RST_MIN_EXP;
      st_ff.cfg.rate_period_us <= `HFTX_RST_RATE_PERIOD;
      st_ff.cfg.delay_us       <= `HFTX_RST_DELAY;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rdata_out               = st_ff.rdata;
  assign frame_trigger_ready_out = st_ff.ready;
  assign frame_start_out         = st_ff.start;
  assign irq_out                 = |(st_ff.irq_status & st_ff.irq_mask);

endmodule // hftx_top

/* File: hftx_trig_src.sv */
// external trigger source model driving the frame trigger pin
`timescale 1ns/1ps

module hftx_trig_src (
  // control from bench
  input  wire logic        clk_in,
  input  wire logic        go_in,
  input  wire logic        fall_in,
  input  wire logic [15:0] len_in,
  // trigger pin
  output logic             pin_out
);
  int left = 0;
  initial pin_out = 1'b0;
  // pin moves off the clock edge, as a real source is unrelated to it
  always @(posedge clk_in) begin
    if (go_in) left = len_in;
    else if (left > 0) left = left - 1;
    pin_out <= #3 ((left > 0) ^ fall_in);
  end
endmodule // hftx_trig_src

/* File: hftx_trig_sync.sv */
// two-flop synchroniser and edge detector for the frame trigger pin
`timescale 1ns/1ps
`include "hftx_defines.svh"

module hftx_trig_sync (
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  // raw pin
  input  wire logic                 pin_in,
  // synchronised level and edges
  output hftx_pkg::hftx_edges_t     edges_out
);
  import hftx_pkg::*;

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } hftx_sync_state_t;

  hftx_sync_state_t state_ff;
  hftx_sync_state_t nxt_state;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_state      = state_ff;
    nxt_state.meta = pin_in;
    nxt_state.sync = state_ff.meta;
    nxt_state.prev = state_ff.sync;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // edges only from the second and third flop, one pulse per transition
  assign edges_out.level = state_ff.sync;
  assign edges_out.rise  = state_ff.sync & ~state_ff.prev;
  assign edges_out.fall  = ~state_ff.sync & state_ff.prev;

endmodule // hftx_trig_sync

/* File: tb.sv */
// self-checking bench of the frame trigger exposure block
`timescale 1ns/1ps
`include "hftx_defines.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end

module tb;
  logic clk_in = 1'b0, rst_in = 1'b1, wr = 1'b0, rd = 1'b0, go = 1'b0, fall = 1'b0, pin;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [15:0] len = 16'h0;
  logic rdy, start, irq;
  int n_mismatch = 0, checked = 0, cyc = 0, t0;
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) cyc <= cyc + 1;

  hftx_top hftx_top_i (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .hw_frame_trigger_input_in(pin), .frame_trigger_ready_out(rdy),
    .frame_start_out(start), .irq_out(irq));
  hftx_trig_src hftx_trig_src_i (.clk_in(clk_in), .go_in(go), .fall_in(fall), .len_in(len), .pin_out(pin));

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in); wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk_in); wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in); rd <= 1'b1; addr <= a;
    @(posedge clk_in); rd <= 1'b0;
    @(posedge clk_in); `CHK(rdata, e)
  endtask
  task automatic pulse(input int l);
    @(posedge clk_in); go <= 1'b1; len <= l[15:0];
    @(posedge clk_in); go <= 1'b0;
  endtask
  task automatic wait_start(input int mx, output int n);
    n = 0;
    while (start !== 1'b1 && n < mx) begin @(posedge clk_in); n++; end
    // a timed-out wait keeps the last start as the reference
    if (start === 1'b1) t0 = cyc;
  endtask
  task automatic wait_rdy(input int mx, output int n);
    n = 0;
    while (rdy !== 1'b1 && n < mx) begin @(posedge clk_in); n++; end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    logic [7:0] ofs [8] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h30};
    logic [31:0] rv [8] = '{32'h0, 32'hBB8, 32'h0, 32'hBB8, 32'h4E20, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 8; i++) rd_chk(ofs[i], rv[i]);
  endtask
  task automatic t_timed(input logic f);
    int n;
    fall <= f;
    wr_reg(`HFTX_OFS_EXPOSURE, 32'h2);
    wr_reg(`HFTX_OFS_CTRL, {29'h0, f, 2'b01});
    wr_reg(`HFTX_OFS_IRQ_MASK, 32'h1);
    wr_reg(`HFTX_OFS_CMD, 32'h1);
    repeat (2) @(posedge clk_in);
    `CHK(rdy, 1'b1)
    pulse(20);
    wait_start(20, n);
    `CHK(n < 8, 1'b1)
    repeat (40) @(posedge clk_in);
    pulse(20);
    repeat (30) @(posedge clk_in);
    `CHK(irq, 1'b1)
    wait_start(150, n);
    `CHK(n, 150)
    wait_rdy(200, n);
    `CHK((cyc - t0) inside {[248:252]}, 1'b1)
    rd_chk(`HFTX_OFS_IRQ_STATUS, 32'h7);
    rd_chk(`HFTX_OFS_IRQ_STATUS, 32'h0);
    `CHK(irq, 1'b0)
    wr_reg(`HFTX_OFS_CMD, 32'h2);
  endtask
  task automatic t_pw(input logic f);
    int n;
    fall <= f;
    wr_reg(`HFTX_OFS_MIN_EXP, 32'h1);
    wr_reg(`HFTX_OFS_CTRL, {28'h0, 1'b1, f, 2'b01});
    wr_reg(`HFTX_OFS_CMD, 32'h1);
    pulse(400);
    wait_start(20, n);
    `CHK(n < 8, 1'b1)
    wait_rdy(200, n);
    `CHK((cyc - t0) inside {[123:127]}, 1'b1)
    repeat (200) @(posedge clk_in);
    rd_chk(`HFTX_OFS_STATUS, {27'h0, ~f, 4'hF});
    repeat (150) @(posedge clk_in);
    // pin back at idle, last exposure still flagged as pulse width
    rd_chk(`HFTX_OFS_STATUS, {27'h0, f, 4'hD});
    wr_reg(`HFTX_OFS_CMD, 32'h2);
  endtask
  task automatic t_delay();
    int n;
    fall <= 1'b0;
    wr_reg(`HFTX_OFS_DELAY, 32'hFFFFFF);
    rd_chk(`HFTX_OFS_DELAY, 32'hF4240);
    wr_reg(`HFTX_OFS_DELAY, 32'h2);
    wr_reg(`HFTX_OFS_CTRL, 32'h1);
    wr_reg(`HFTX_OFS_CMD, 32'h1);
    pulse(20);
    wait_start(240, n);
    `CHK(n, 240)
    wait_start(40, n);
    `CHK(n < 40, 1'b1)
    wait_rdy(300, n);
    wr_reg(`HFTX_OFS_CTRL, 32'h3); // no delay for the software source
    wr_reg(`HFTX_OFS_CMD, 32'h4);
    wait_start(10, n);
    `CHK(n < 10, 1'b1)
    wait_rdy(300, n);
    wr_reg(`HFTX_OFS_CMD, 32'h2);
    wr_reg(`HFTX_OFS_DELAY, 32'h0);
  endtask
  task automatic t_rate();
    int n;
    wr_reg(`HFTX_OFS_RATE_PERIOD, 32'h4);
    wr_reg(`HFTX_OFS_CTRL, 32'h11);
    wr_reg(`HFTX_OFS_CMD, 32'h1);
    repeat (500) @(posedge clk_in);
    pulse(20);
    wait_start(20, n);
    `CHK(n < 8, 1'b1)
    wait_rdy(300, n);
    // gate set: an edge inside the period is refused
    pulse(20);
    wait_start(100, n);
    `CHK(n, 100)
    rd_chk(`HFTX_OFS_IRQ_STATUS, 32'h7);
    repeat (200) @(posedge clk_in);
    pulse(20);
    wait_start(20, n);
    `CHK(n < 8, 1'b1)
    wait_rdy(300, n);
    // trigger off: free run, back to back, delay not applied
    wr_reg(`HFTX_OFS_DELAY, 32'h2);
    wr_reg(`HFTX_OFS_CTRL, 32'h0);
    wait_start(10, n);
    `CHK(n < 10, 1'b1)
    wait_rdy(300, n);
    wait_start(4, n);
    `CHK(n < 4, 1'b1)
    wr_reg(`HFTX_OFS_CMD, 32'h2);
  endtask

  task automatic stop_test();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_timed(1'b0);
    t_timed(1'b1);
    t_pw(1'b0);
    t_pw(1'b1);
    t_delay();
    t_rate();
    stop_test();
  end
  // whole run needs about 4000 cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    stop_test();
  end
endmodule // tb
